// file: pin_sync.v
`timescale 1ns/1ps
// three-stage pin synchroniser; output moves only when stages two and three agree
module pin_sync #(
  parameter WIDTH = 1
) (
  input  wire             mclk_i,
  input  wire             resetn_i,
  input  wire [WIDTH-1:0] pin_i,
  output wire [WIDTH-1:0] level_o
);

  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;
  reg [WIDTH-1:0] stage3_reg;
  reg [WIDTH-1:0] level_reg;

  genvar g;

  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      stage1_reg <= {WIDTH{1'b0}};
      stage2_reg <= {WIDTH{1'b0}};
      stage3_reg <= {WIDTH{1'b0}};
    end else begin
      stage1_reg <= pin_i;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // stage one feeds only stage two; agreement filter looks at two and three
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : bit_filter
      always @(posedge mclk_i) begin
        if (!resetn_i) begin
          level_reg[g] <= 1'b0;
        end else if (stage2_reg[g] == stage3_reg[g]) begin
          level_reg[g] <= stage3_reg[g];
        end
      end
    end
  endgenerate

  assign level_o = level_reg;

endmodule

// file: sci_checker_assertions.sv
`timescale 1ns/1ps
module sci_checker (
  input wire       mclk_i,
  input wire       resetn_i,
  input wire       serial_sel_i,
  input wire       path_ctrl_1_i,
  input wire       path_ctrl_2_i,
  input wire       path_ctrl_3_i,
  input wire       path_ctrl_4_i,
  input wire       path_ctrl_4_o,
  input wire       path_ctrl_4_oe_n_o,
  input wire [1:0] config_error_i,
  input wire [3:0] branch_on_o,
  input wire       daisy_mode_o
);
  wire [3:0] pins;
  wire       sel;
  wire       cs_n;
  wire       oe_n;
  assign pins = {path_ctrl_4_i, path_ctrl_3_i, path_ctrl_2_i, path_ctrl_1_i};
  assign sel = serial_sel_i;
  assign cs_n = path_ctrl_2_i;
  assign oe_n = path_ctrl_4_oe_n_o;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  // eight cycles outlast the pin synchroniser
  property p_par; (!sel && $stable(pins))[*8] |-> branch_on_o == pins; endproperty
  a_par: assert property (p_par) else $error("branch mismatch");
  property p_rst; $rose(resetn_i) |-> branch_on_o == 4'h0 && !daisy_mode_o; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_hold; daisy_mode_o |=> daisy_mode_o; endproperty
  a_hold: assert property (p_hold) else $error("daisy mode lost");
  property p_poe; (!sel)[*8] |-> oe_n; endproperty
  a_poe: assert property (p_poe) else $error("sdo driven in parallel");
  property p_ioe; (sel && cs_n)[*8] |-> oe_n; endproperty
  a_ioe: assert property (p_ioe) else $error("sdo driven when idle");
  property p_doe; (sel && !cs_n)[*8] |-> !oe_n; endproperty
  a_doe: assert property (p_doe) else $error("sdo not driven");
  // with select steady, sdo may only move after a clock fall, never while sclk is high
  property p_sdo; (sel && path_ctrl_3_i && $stable(cs_n))[*8] |-> $stable(path_ctrl_4_o);
  endproperty
  a_sdo: assert property (p_sdo) else $error("sdo moved on rise");
  property p_brd; (daisy_mode_o && sel && !cs_n)[*8] |-> $stable(branch_on_o); endproperty
  a_brd: assert property (p_brd) else $error("branch moved in frame");
  c_entry: cover property ($rose(daisy_mode_o));
  c_all: cover property (branch_on_o == 4'hF);
  c_drive: cover property ($fell(oe_n));
endmodule
bind switch_control_interface sci_checker chk (
  .mclk_i, .resetn_i, .serial_sel_i, .path_ctrl_1_i, .path_ctrl_2_i, .path_ctrl_3_i,
  .path_ctrl_4_i, .path_ctrl_4_o, .path_ctrl_4_oe_n_o, .config_error_i, .branch_on_o,
  .daisy_mode_o);

// file: spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
  input  wire mclk_i,
  input  wire sdo_i,
  output reg  sdi_o,
  output reg  cs_n_o,
  output reg  sclk_o
);
  initial begin
    sdi_o = 1'b0;
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
  end
  // half of the 64 ns link period
  task half;
    begin
      repeat (8) @(negedge mclk_i);
    end
  endtask
  // mode 0, msb first; sdo taken at each rise
  task xfer(input [15:0] w, input integer n, output [15:0] r);
    integer i;
    begin
      r = 16'h0000;
      cs_n_o = 1'b0;
      for (i = 0; i < n; i = i + 1) begin
        sdi_o = w[15 - i];
        half;
        sclk_o = 1'b1;
        r = {r[14:0], sdo_i};
        half;
        sclk_o = 1'b0;
      end
      half;
      cs_n_o = 1'b1;
      // released line shows no stale bit
      sdi_o = ~sdi_o;
      half;
      half;
    end
  endtask
  // mode 3: clock idles high, first fall carries no bit
  task xfer_m3(input [15:0] w, output [15:0] r);
    integer i;
    begin
      r = 16'h0000;
      sclk_o = 1'b1;
      half;
      cs_n_o = 1'b0;
      for (i = 0; i < 16; i = i + 1) begin
        half;
        sclk_o = 1'b0;
        sdi_o = w[15 - i];
        half;
        sclk_o = 1'b1;
        r = {r[14:0], sdo_i};
      end
      half;
      cs_n_o = 1'b1;
      half;
      // back to mode 0 idle level while deselected
      sclk_o = 1'b0;
      half;
    end
  endtask
endmodule

// file: switch_control_interface.v
`timescale 1ns/1ps
`include "switch_ctrl_consts.vh"
module switch_control_interface (
  input  wire       mclk_i,
  input  wire       resetn_i,
  input  wire       serial_sel_i,
  input  wire       path_ctrl_1_i,
  input  wire       path_ctrl_2_i,
  input  wire       path_ctrl_3_i,
  input  wire       path_ctrl_4_i,
  output wire       path_ctrl_4_o,
  output wire       path_ctrl_4_oe_n_o,
  input  wire [1:0] config_error_i,
  output wire [3:0] branch_on_o,
  output wire       daisy_mode_o
);

  // synchronised pin levels
  wire [4:0] pins_sync;
  wire       sel_s;
  wire       sdi_s;
  wire       csn_s;
  wire       sclk_s;
  wire [3:0] par_s;

  pin_sync #(
    .WIDTH (5)
  ) u_pin_sync (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .pin_i    ({serial_sel_i, path_ctrl_4_i, path_ctrl_3_i, path_ctrl_2_i, path_ctrl_1_i}),
    .level_o  (pins_sync)
  );

  // pin 1 carries SDI, pin 2 chip select, pin 3 SCLK in serial mode
  assign sel_s  = pins_sync[4];
  assign par_s  = pins_sync[3:0];
  assign sdi_s  = pins_sync[0];
  assign csn_s  = pins_sync[1];
  assign sclk_s = pins_sync[2];

  // state
  reg        csn_prev_reg;
  reg        sclk_prev_reg;
  reg        daisy_reg;
  reg [4:0]  rise_cnt_reg;
  reg [15:0] rx_sr_reg;
  reg        rw_reg;
  reg [6:0]  addr_reg;
  reg [7:0]  tx_sr_reg;
  reg        sdo_reg;
  reg [7:0]  chain_sr_reg;
  reg        chain_out_reg;
  reg [5:0]  ctrl_reg;
  reg [1:0]  err_reg;
  reg        err_caught_reg;
  reg [3:0]  branch_reg;

  // next values
  reg [4:0]  rise_cnt_next;
  reg [15:0] rx_sr_next;
  reg        rw_next;
  reg [6:0]  addr_next;
  reg [7:0]  tx_sr_next;
  reg        sdo_next;
  reg [7:0]  chain_sr_next;
  reg        chain_out_next;
  reg [5:0]  ctrl_next;
  reg        daisy_next;

  wire       serial_on;
  wire       frame_on;
  wire       cs_fall;
  wire       cs_rise;
  wire       sclk_rise;
  wire       sclk_fall;
  wire [7:0] read_data;
  wire [15:0] rx_word;

  assign serial_on = sel_s;
  assign frame_on  = serial_on & ~csn_s;
  assign cs_fall   = serial_on & csn_prev_reg & ~csn_s;
  assign cs_rise   = serial_on & ~csn_prev_reg & csn_s;
  // edges on a 10 MHz SCLK are spaced far beyond the synchroniser delay
  assign sclk_rise = frame_on & ~sclk_prev_reg & sclk_s;
  assign sclk_fall = frame_on & sclk_prev_reg & ~sclk_s;

  assign read_data = {err_reg, ctrl_reg};
  assign rx_word   = {rx_sr_reg[14:0], sdi_s};

  always @* begin
    rise_cnt_next  = rise_cnt_reg;
    rx_sr_next     = rx_sr_reg;
    rw_next        = rw_reg;
    addr_next      = addr_reg;
    tx_sr_next     = tx_sr_reg;
    sdo_next       = sdo_reg;
    chain_sr_next  = chain_sr_reg;
    chain_out_next = chain_out_reg;
    ctrl_next      = ctrl_reg;
    daisy_next     = daisy_reg;

    if (!daisy_reg) begin
      if (cs_fall) begin
        // alignment byte leaves on the select edge itself in mode 0
        rise_cnt_next = 5'd0;
        tx_sr_next    = `ALIGN_PATTERN;
        sdo_next      = tx_sr_next[7];
      end else begin
        if (sclk_rise && (rise_cnt_reg != `FRAME_BITS)) begin
          rx_sr_next    = rx_word;
          rise_cnt_next = rise_cnt_reg + 5'd1;
          if (rise_cnt_next == `ADDR_DONE_BITS) begin
            rw_next   = rx_word[7];
            addr_next = rx_word[6:0];
          end
          if (rise_cnt_next == `FRAME_BITS) begin
            // entry command takes precedence over its write meaning
            if (rx_word == `DAISY_ENTRY_CMD) begin
              daisy_next    = 1'b1;
              chain_sr_next = 8'h00;
              chain_out_next = 1'b0;
            end else if ((rw_reg != `RW_READ) &&
                         (addr_reg == `SWITCH_DATA_ADDR)) begin
              ctrl_next = rx_word[`CTRL_HI:`CTRL_LO];
            end
          end
        end
        // mode 3: no rise yet, so the first fall is skipped
        if (sclk_fall && (rise_cnt_reg != 5'd0)) begin
          if (rise_cnt_reg == `ADDR_DONE_BITS) begin
            if ((rw_reg == `RW_READ) && (addr_reg == `SWITCH_DATA_ADDR)) begin
              tx_sr_next = read_data;
            end else begin
              // zeros after the alignment byte pass the entry command on
              tx_sr_next = 8'h00;
            end
          end else begin
            tx_sr_next = {tx_sr_reg[6:0], 1'b0};
          end
          sdo_next = tx_sr_next[7];
        end
      end
    end else begin
      if (cs_fall) begin
        sdo_next = chain_out_reg;
      end
      if (sclk_rise) begin
        // bit leaving after this shift, so downstream sees it eight rises later
        chain_out_next = chain_sr_reg[6];
        chain_sr_next  = {chain_sr_reg[6:0], sdi_s};
      end
      if (sclk_fall) begin
        sdo_next = chain_out_reg;
      end
      if (cs_rise) begin
        // partial byte counts still load the most recent six bits
        ctrl_next = chain_sr_reg[`CTRL_HI:`CTRL_LO];
      end
    end
  end

  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      csn_prev_reg   <= 1'b1;
      sclk_prev_reg  <= 1'b0;
      daisy_reg      <= 1'b0;
      rise_cnt_reg   <= 5'd0;
      rx_sr_reg      <= 16'h0000;
      rw_reg         <= 1'b0;
      addr_reg       <= 7'h00;
      tx_sr_reg      <= 8'h00;
      sdo_reg        <= 1'b0;
      chain_sr_reg   <= 8'h00;
      chain_out_reg  <= 1'b0;
      ctrl_reg       <= `SWITCH_CTRL_RESET;
    end else begin
      csn_prev_reg   <= csn_s;
      sclk_prev_reg  <= sclk_s;
      daisy_reg      <= daisy_next;
      rise_cnt_reg   <= rise_cnt_next;
      rx_sr_reg      <= rx_sr_next;
      rw_reg         <= rw_next;
      addr_reg       <= addr_next;
      tx_sr_reg      <= tx_sr_next;
      sdo_reg        <= sdo_next;
      chain_sr_reg   <= chain_sr_next;
      chain_out_reg  <= chain_out_next;
      ctrl_reg       <= ctrl_next;
    end
  end

  // configuration error caught once, on the first edge after reset release
  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      err_reg        <= 2'b00;
      err_caught_reg <= 1'b0;
    end else if (!err_caught_reg) begin
      err_reg        <= config_error_i;
      err_caught_reg <= 1'b1;
    end
  end

  // branch drive: each bit independent, so all sixteen patterns are legal
  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      branch_reg <= 4'h0;
    end else if (serial_on) begin
      branch_reg <= ctrl_reg[`BRANCH_HI:0];
    end else begin
      branch_reg <= par_s;
    end
  end

  assign branch_on_o        = branch_reg;
  assign daisy_mode_o       = daisy_reg;
  assign path_ctrl_4_o      = sdo_reg;
  // driven only inside a serial frame; released otherwise
  assign path_ctrl_4_oe_n_o = ~frame_on;

endmodule

// file: switch_control_interface_tb.sv
`timescale 1ns/1ps
module switch_control_interface_tb;
  reg        mclk_i;
  reg        resetn_i;
  reg        serial_sel_i;
  reg  [3:0] par;
  reg  [15:0] r;
  wire       sdi;
  wire       cs_n;
  wire       sclk;
  wire       sdo;
  wire       oe_n;
  wire       pin4;
  wire [3:0] branch_on_o;
  wire       daisy_mode_o;
  integer    mismatches;
  integer    n_tests;
  integer    k;
  assign pin4 = oe_n ? par[3] : sdo;
  switch_control_interface uut (
    .mclk_i             (mclk_i),
    .resetn_i           (resetn_i),
    .serial_sel_i       (serial_sel_i),
    .path_ctrl_1_i      (serial_sel_i ? sdi : par[0]),
    .path_ctrl_2_i      (serial_sel_i ? cs_n : par[1]),
    .path_ctrl_3_i      (serial_sel_i ? sclk : par[2]),
    .path_ctrl_4_i      (pin4),
    .path_ctrl_4_o      (sdo),
    .path_ctrl_4_oe_n_o (oe_n),
    .config_error_i     (2'b10),
    .branch_on_o        (branch_on_o),
    .daisy_mode_o       (daisy_mode_o)
  );
  spi_host_model host (.mclk_i(mclk_i), .sdo_i(pin4), .sdi_o(sdi), .cs_n_o(cs_n), .sclk_o(sclk));
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  task stop_test;
    begin
      $display("mismatches %0d n_tests %0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task check(input [15:0] got, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task br(input [3:0] e);
    begin
      repeat (8) @(negedge mclk_i);
      check({12'h000, branch_on_o}, {12'h000, e});
    end
  endtask
  task t_parallel;
    begin
      for (k = 0; k < 16; k = k + 1) begin
        par = k[3:0];
        br(k[3:0]);
      end
      $display("parallel test done");
    end
  endtask
  task t_serial;
    begin
      check({15'h0000, daisy_mode_o}, 16'h0000);
      host.xfer(16'h0003, 16, r);
      check(r, 16'h2500);
      br(4'h3);
      host.xfer(16'h8000, 16, r);
      check(r, 16'h2583);
      host.xfer_m3(16'h8000, r);
      check(r, 16'h2583);
      // other address: write dropped
      host.xfer(16'h0530, 16, r);
      br(4'h3);
      par = 4'h0;
      serial_sel_i = 1'b0;
      br(4'h0);
      serial_sel_i = 1'b1;
      br(4'h3);
      $display("serial test done");
    end
  endtask
  task t_daisy;
    begin
      host.xfer(16'h2500, 16, r);
      check(r, 16'h2500);
      check({15'h0000, daisy_mode_o}, 16'h0001);
      // cleared chain: eight zeros, then the first byte sent
      host.xfer(16'hA53C, 16, r);
      check(r, 16'h00A5);
      br(4'hC);
      // twelve clocks, not a multiple of eight
      host.xfer(16'h8120, 12, r);
      check({4'h0, r[11:0]}, 16'h03C8);
      br(4'h2);
      check({15'h0000, daisy_mode_o}, 16'h0001);
      $display("daisy test done");
    end
  endtask
  initial begin
    repeat (100000) @(posedge mclk_i);
    mismatches = mismatches + 1;
    stop_test;
  end
  initial begin
    mismatches = 0;
    n_tests = 0;
    resetn_i = 1'b0;
    serial_sel_i = 1'b0;
    par = 4'h0;
    repeat (16) @(negedge mclk_i);
    resetn_i = 1'b1;
    t_parallel;
    serial_sel_i = 1'b1;
    repeat (2500) @(negedge mclk_i);
    t_serial;
    t_daisy;
    resetn_i = 1'b0;
    repeat (16) @(negedge mclk_i);
    resetn_i = 1'b1;
    br(4'h0);
    check({15'h0000, daisy_mode_o}, 16'h0000);
    stop_test;
  end
endmodule

// file: switch_ctrl_consts.vh
`ifndef SWITCH_CTRL_CONSTS_VH
`define SWITCH_CTRL_CONSTS_VH

// serial frame layout
`define FRAME_BITS        5'd16
`define ADDR_DONE_BITS    5'd8
`define DAISY_STAGE_BITS  8

// alignment byte sent at the head of every addressable frame
`define ALIGN_PATTERN     8'h25

// command word that moves the interface into daisy-chain mode
`define DAISY_ENTRY_CMD   16'h2500

// read/write indicator value meaning read
`define RW_READ           1'b1

// switch data register address and field positions
`define SWITCH_DATA_ADDR  7'h00
`define ERR_HI            7
`define ERR_LO            6
`define CTRL_HI           5
`define CTRL_LO           0
`define BRANCH_HI         3

// reset value of the writable part of the switch data register
`define SWITCH_CTRL_RESET 6'h00

// pin synchroniser depth
`define SYNC_STAGES       3

`endif
